// >>> inc/dscreg_pkg.sv
package dscreg_pkg;
  // Word indices; byte offset on the bus is index times four
  localparam int unsigned NUM_WORDS = 28;
  localparam int unsigned SHADOW_WORDS = 4;
  localparam logic [4:0] IDX_FP = 5'h0e;
  localparam logic [4:0] IDX_SP = 5'h0f;
  localparam logic [4:0] IDX_ACCUMULATOR_A_L = 5'h10;
  localparam logic [4:0] IDX_ACCUMULATOR_A_H = 5'h11;
  localparam logic [4:0] IDX_ACCUMULATOR_A_U = 5'h12;
  localparam logic [4:0] IDX_ACCUMULATOR_B_L = 5'h13;
  localparam logic [4:0] IDX_ACCUMULATOR_B_H = 5'h14;
  localparam logic [4:0] IDX_ACCUMULATOR_B_U = 5'h15;
  localparam logic [4:0] IDX_SR = 5'h16;
  localparam logic [4:0] IDX_TABLE_PAGE_REG = 5'h17;
  localparam logic [4:0] IDX_CORE_CONTROL_REG = 5'h18;
  localparam logic [4:0] IDX_LP_START = 5'h19;
  localparam logic [4:0] IDX_LP_END = 5'h1a;
  localparam logic [4:0] IDX_LP_COUNT = 5'h1b;
  localparam logic [4:0] IDX_PC_L = 5'h1c;
  localparam logic [4:0] IDX_PC_H = 5'h1d;
  // Reset and step values
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam logic [15:0] SP_WORD = 16'h0002;
  localparam logic [15:0] SP_CALL_STEP = 16'h0004;
  localparam logic [22:0] PC_STEP = 23'h000002;
  // Status, control and table page word bit positions
  localparam int unsigned SR_DA = 9;
  localparam logic [15:0] SR_SHADOW_MASK = 16'h010f;
  localparam int unsigned CORE_CONTROL_REG_WRITE_SATURATE_ENABLE = 0;
  localparam int unsigned TABLE_PAGE_REG_CFG = 7;
  // Program space and saturation limits
  localparam logic [23:0] PROG_USER_MAX = 24'h7ffffe;
  localparam logic [15:0] SAT_POS = 16'h7fff;
  localparam logic [15:0] SAT_NEG = 16'h8000;
  // Shifter sources
  localparam logic [1:0] SRC_ACCUMULATOR_A = 2'h0;
  localparam logic [1:0] SRC_ACCUMULATOR_B = 2'h1;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    WS_COLLECT = 2'b00,
    WS_COMMIT = 2'b01,
    WS_RESP = 2'b11
  } dscreg_ws_t;
endpackage

// >>> logic/dscreg_shift.sv
module dscreg_shift (
  input wire logic [1:0] src_sel,
  input wire logic [39:0] acc_a,
  input wire logic [39:0] acc_b,
  input wire logic [15:0] xbus,
  input wire logic [5:0] count,
  input wire logic arith,
  output logic [39:0] result
);
  logic [39:0] opnd;
  logic [5:0] neg;
  logic fill;

  // Operand select; X data placed by direction
  always_comb begin
    fill = arith & xbus[15];
    neg = 6'h00 - count;
    case (src_sel)
      dscreg_pkg::SRC_ACCUMULATOR_A: opnd = acc_a;
      dscreg_pkg::SRC_ACCUMULATOR_B: opnd = acc_b;
      default: begin
        if (count[5]) begin
          opnd = {24'h000000, xbus};
        end else begin
          opnd = {{8{fill}}, xbus, 16'h0000};
        end
      end
    endcase
  end

  // Single-cycle shift, sign of count picks direction
  always_comb begin
    if (count[5]) begin
      result = opnd << neg[4:0];
    end else if (arith) begin
      result = 40'($signed(opnd) >>> count[4:0]);
    end else begin
      result = opnd >> count[4:0];
    end
  end
endmodule

// >>> logic/dscreg_core.sv
module dscreg_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core_wr_en,
  input wire logic [4:0] core_wr_idx,
  input wire logic core_wr_byte,
  input wire logic [15:0] core_wr_data,
  input wire logic [4:0] core_rd_idx,
  output logic [15:0] core_rd_data_q,
  input wire logic acc_wr_en,
  input wire logic acc_wr_sel,
  input wire logic [39:0] acc_wr_data,
  input wire logic call_push,
  input wire logic call_return,
  input wire logic exc_entry,
  input wire logic frame_link,
  input wire logic frame_unlink,
  input wire logic [15:0] frame_size,
  input wire logic shadow_push,
  input wire logic shadow_pop,
  input wire logic loop_start,
  input wire logic loop_end,
  input wire logic [15:0] loop_start_val,
  input wire logic [15:0] loop_end_val,
  input wire logic [15:0] loop_count_val,
  output logic [15:0] exc_word_q,
  output logic exc_word_valid_q,
  input wire logic pc_load,
  input wire logic [22:0] pc_load_val,
  input wire logic pc_step,
  output logic [22:0] pc_q,
  input wire logic prog_req,
  input wire logic [23:0] prog_addr,
  input wire logic prog_table,
  output logic prog_ok_q,
  output logic prog_cfg_q,
  input wire logic sat_req,
  input wire logic sat_acc_sel,
  input wire logic [15:0] sat_in,
  input wire logic sat_round_ovf,
  output logic [15:0] sat_out_q,
  output logic sat_valid_q,
  input wire logic shf_req,
  input wire logic [1:0] shf_src,
  input wire logic [15:0] shf_xbus,
  input wire logic [5:0] shf_count,
  input wire logic shf_arith,
  output logic [39:0] shf_out_q,
  output logic [15:0] shf_int_q,
  output logic shf_valid_q
);
  logic [15:0] regs_q [0:dscreg_pkg::NUM_WORDS-1];
  logic [15:0] shd_w_q [0:dscreg_pkg::SHADOW_WORDS-1];
  logic [15:0] shd_sr_q;
  logic [15:0] shd_lp_q [0:2];
  dscreg_pkg::dscreg_ws_t ws_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [15:0] wdata_q;
  logic [1:0] wstrb_q;
  logic aw_take;
  logic w_take;
  logic [5:0] wdec;
  logic [5:0] rdec;
  logic bus_wr;
  logic [15:0] sp;
  logic write_saturate_enable;
  logic [39:0] sat_acc;
  logic sat_ovf;
  logic [39:0] acc_a;
  logic [39:0] acc_b;
  logic [39:0] shf_res;

  // Bus address to {hit, word index}
  function automatic logic [5:0] dec(input logic [7:0] a);
    dec = {a[1:0] == 2'b00 && !a[7] && a[6:2] <= dscreg_pkg::IDX_PC_H, a[6:2]};
  endfunction

  // 40-bit accumulator view of three words
  function automatic logic [39:0] acc_val(input logic sel);
    if (sel) begin
      acc_val = {regs_q[dscreg_pkg::IDX_ACCUMULATOR_B_U][7:0], regs_q[dscreg_pkg::IDX_ACCUMULATOR_B_H],
                 regs_q[dscreg_pkg::IDX_ACCUMULATOR_B_L]};
    end else begin
      acc_val = {regs_q[dscreg_pkg::IDX_ACCUMULATOR_A_U][7:0], regs_q[dscreg_pkg::IDX_ACCUMULATOR_A_H],
                 regs_q[dscreg_pkg::IDX_ACCUMULATOR_A_L]};
    end
  endfunction

  // Software-visible word; shadows have no index at all
  function automatic logic [15:0] rd_word(input logic [4:0] idx);
    if (idx == dscreg_pkg::IDX_PC_L) begin
      rd_word = pc_q[15:0];
    end else if (idx == dscreg_pkg::IDX_PC_H) begin
      rd_word = {9'h000, pc_q[22:16]};
    end else if (idx < dscreg_pkg::IDX_PC_L) begin
      rd_word = regs_q[idx];
    end else begin
      rd_word = 16'h0000;
    end
  endfunction

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wdec = dec(awaddr_q);
  assign rdec = dec(s_axi_araddr);
  assign bus_wr = ce && ws_q == dscreg_pkg::WS_COMMIT && wdec[5];
  assign sp = regs_q[dscreg_pkg::IDX_SP];
  assign write_saturate_enable = regs_q[dscreg_pkg::IDX_CORE_CONTROL_REG][dscreg_pkg::CORE_CONTROL_REG_WRITE_SATURATE_ENABLE];
  // Procedural, so the register words read inside the function wake it up
  always_comb begin
    acc_a = acc_val(1'b0);
    acc_b = acc_val(1'b1);
    sat_acc = acc_val(sat_acc_sel);
  end

  // Write channel: address and data in either order, then one answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ws_q <= dscreg_pkg::WS_COLLECT;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dscreg_pkg::RESP_OKAY;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
    end else if (ce) begin
      case (ws_q)
        dscreg_pkg::WS_COLLECT: begin
          if (aw_take) begin
            awaddr_q <= s_axi_awaddr;
            aw_got_q <= 1'b1;
            s_axi_awready <= 1'b0;
          end
          if (w_take) begin
            wdata_q <= s_axi_wdata[15:0];
            wstrb_q <= s_axi_wstrb[1:0];
            w_got_q <= 1'b1;
            s_axi_wready <= 1'b0;
          end
          if ((aw_got_q || aw_take) && (w_got_q || w_take)) begin
            ws_q <= dscreg_pkg::WS_COMMIT;
          end
        end
        dscreg_pkg::WS_COMMIT: begin
          s_axi_bvalid <= 1'b1;
          s_axi_bresp <= wdec[5] ? dscreg_pkg::RESP_OKAY : dscreg_pkg::RESP_SLVERR;
          ws_q <= dscreg_pkg::WS_RESP;
        end
        dscreg_pkg::WS_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            ws_q <= dscreg_pkg::WS_COLLECT;
          end
        end
        default: ws_q <= dscreg_pkg::WS_COLLECT;
      endcase
    end
  end

  // Read channel: one read in flight, data one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= dscreg_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
          s_axi_arready <= 1'b1;
        end
      end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rdec[5] ? rd_word(rdec[4:0]) : 16'h0000};
        s_axi_rresp <= rdec[5] ? dscreg_pkg::RESP_OKAY : dscreg_pkg::RESP_SLVERR;
      end
    end
  end

  // Register file; later writers in this block win
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < dscreg_pkg::NUM_WORDS; i++) begin
        regs_q[i] <= 16'h0000;
      end
      regs_q[dscreg_pkg::IDX_SP] <= dscreg_pkg::SP_RESET;
    end else if (ce) begin
      // Bus may write either byte alone; PC words are read-only
      if (bus_wr && wdec[4:0] < dscreg_pkg::IDX_PC_L) begin
        if (wstrb_q[0]) begin
          regs_q[wdec[4:0]][7:0] <= wdata_q[7:0];
        end
        if (wstrb_q[1]) begin
          regs_q[wdec[4:0]][15:8] <= wdata_q[15:8];
        end
      end
      // Core write; byte ops leave the upper byte alone
      if (core_wr_en && core_wr_idx < dscreg_pkg::IDX_PC_L) begin
        regs_q[core_wr_idx][7:0] <= core_wr_data[7:0];
        if (!core_wr_byte) begin
          regs_q[core_wr_idx][15:8] <= core_wr_data[15:8];
        end
      end
      if (acc_wr_en) begin
        if (acc_wr_sel) begin
          regs_q[dscreg_pkg::IDX_ACCUMULATOR_B_L] <= acc_wr_data[15:0];
          regs_q[dscreg_pkg::IDX_ACCUMULATOR_B_H] <= acc_wr_data[31:16];
          regs_q[dscreg_pkg::IDX_ACCUMULATOR_B_U] <= {8'h00, acc_wr_data[39:32]};
        end else begin
          regs_q[dscreg_pkg::IDX_ACCUMULATOR_A_L] <= acc_wr_data[15:0];
          regs_q[dscreg_pkg::IDX_ACCUMULATOR_A_H] <= acc_wr_data[31:16];
          regs_q[dscreg_pkg::IDX_ACCUMULATOR_A_U] <= {8'h00, acc_wr_data[39:32]};
        end
      end
      // Automatic stack pointer moves, frame link and unlink
      if (exc_entry || call_push) begin
        regs_q[dscreg_pkg::IDX_SP] <= sp + dscreg_pkg::SP_CALL_STEP;
      end else if (call_return) begin
        regs_q[dscreg_pkg::IDX_SP] <= sp - dscreg_pkg::SP_CALL_STEP;
      end else if (frame_link) begin
        regs_q[dscreg_pkg::IDX_FP] <= sp + dscreg_pkg::SP_WORD;
        regs_q[dscreg_pkg::IDX_SP] <= sp + dscreg_pkg::SP_WORD + frame_size;
      end else if (frame_unlink) begin
        regs_q[dscreg_pkg::IDX_SP] <= regs_q[dscreg_pkg::IDX_FP] - dscreg_pkg::SP_WORD;
      end
      // Shadow restore touches only four registers and five flags
      if (shadow_pop) begin
        for (int i = 0; i < dscreg_pkg::SHADOW_WORDS; i++) begin
          regs_q[i] <= shd_w_q[i];
        end
        regs_q[dscreg_pkg::IDX_SR] <= (regs_q[dscreg_pkg::IDX_SR] & ~dscreg_pkg::SR_SHADOW_MASK)
                                      | (shd_sr_q & dscreg_pkg::SR_SHADOW_MASK);
      end
      // Loop start loads new bounds, loop end brings back the outer ones
      if (loop_start) begin
        regs_q[dscreg_pkg::IDX_LP_START] <= loop_start_val;
        regs_q[dscreg_pkg::IDX_LP_END] <= loop_end_val;
        regs_q[dscreg_pkg::IDX_LP_COUNT] <= loop_count_val;
        regs_q[dscreg_pkg::IDX_SR][dscreg_pkg::SR_DA] <= 1'b1;
      end else if (loop_end) begin
        for (int i = 0; i < 3; i++) begin
          regs_q[int'(dscreg_pkg::IDX_LP_START) + i] <= shd_lp_q[i];
        end
        regs_q[dscreg_pkg::IDX_SR][dscreg_pkg::SR_DA] <= 1'b0;
      end
      // Hard-wired zeros win over every writer
      regs_q[dscreg_pkg::IDX_SP][0] <= 1'b0;
      regs_q[dscreg_pkg::IDX_ACCUMULATOR_A_U][15:8] <= 8'h00;
      regs_q[dscreg_pkg::IDX_ACCUMULATOR_B_U][15:8] <= 8'h00;
    end
  end

  // Shadow capture; no bus path reaches these
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < dscreg_pkg::SHADOW_WORDS; i++) begin
        shd_w_q[i] <= 16'h0000;
      end
      for (int i = 0; i < 3; i++) begin
        shd_lp_q[i] <= 16'h0000;
      end
      shd_sr_q <= 16'h0000;
    end else if (ce) begin
      if (shadow_push) begin
        for (int i = 0; i < dscreg_pkg::SHADOW_WORDS; i++) begin
          shd_w_q[i] <= regs_q[i];
        end
        shd_sr_q <= regs_q[dscreg_pkg::IDX_SR] & dscreg_pkg::SR_SHADOW_MASK;
      end
      if (loop_start) begin
        for (int i = 0; i < 3; i++) begin
          shd_lp_q[i] <= regs_q[int'(dscreg_pkg::IDX_LP_START) + i];
        end
      end
    end
  end

  // Program counter and exception stack word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= 23'h000000;
      exc_word_q <= 16'h0000;
      exc_word_valid_q <= 1'b0;
    end else if (ce) begin
      if (pc_load) begin
        pc_q <= {pc_load_val[22:1], 1'b0};
      end else if (pc_step) begin
        pc_q <= pc_q + dscreg_pkg::PC_STEP;
      end
      exc_word_valid_q <= exc_entry;
      if (exc_entry) begin
        exc_word_q <= {regs_q[dscreg_pkg::IDX_SR][7:0], 1'b0, pc_q[22:16]};
      end
    end
  end

  // Core read port and program-space access check
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_rd_data_q <= 16'h0000;
      prog_ok_q <= 1'b0;
      prog_cfg_q <= 1'b0;
    end else if (ce) begin
      core_rd_data_q <= rd_word(core_rd_idx);
      if (prog_req) begin
        prog_ok_q <= prog_table || prog_addr <= dscreg_pkg::PROG_USER_MAX;
        prog_cfg_q <= prog_table
                      && regs_q[dscreg_pkg::IDX_TABLE_PAGE_REG][dscreg_pkg::TABLE_PAGE_REG_CFG];
      end
    end
  end

  // Overflow from accumulator guard bits or the round adder
  assign sat_ovf = sat_round_ovf || sat_acc[39:31] != {9{sat_acc[39]}};

  // Write saturation only shapes the output; accumulator is untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sat_out_q <= 16'h0000;
      sat_valid_q <= 1'b0;
    end else if (ce) begin
      sat_valid_q <= sat_req;
      if (sat_req) begin
        if (write_saturate_enable && sat_ovf) begin
          sat_out_q <= sat_acc[39] ? dscreg_pkg::SAT_NEG : dscreg_pkg::SAT_POS;
        end else begin
          sat_out_q <= sat_in;
        end
      end
    end
  end

  dscreg_shift u_shift (
    .src_sel(shf_src),
    .acc_a(acc_a),
    .acc_b(acc_b),
    .xbus(shf_xbus),
    .count(shf_count),
    .arith(shf_arith),
    .result(shf_res)
  );

  // Shifter result; integer view depends on direction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shf_out_q <= 40'h0000000000;
      shf_int_q <= 16'h0000;
      shf_valid_q <= 1'b0;
    end else if (ce) begin
      shf_valid_q <= shf_req;
      if (shf_req) begin
        shf_out_q <= shf_res;
        shf_int_q <= shf_count[5] ? shf_res[15:0] : shf_res[31:16];
      end
    end
  end

  AST_SP_RESET: assert property (
    @(posedge aclk) $rose(aresetn) |-> sp == dscreg_pkg::SP_RESET)
    else $error("stack pointer not at reset value");

  AST_SP_ALIGN: assert property (
    @(posedge aclk) disable iff (!aresetn) sp[0] == 1'b0)
    else $error("stack pointer odd");

  AST_BYTE_OP: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && core_wr_en && core_wr_byte && core_wr_idx == 5'h00 && !bus_wr && !shadow_pop
    |=> regs_q[0][15:8] == $past(regs_q[0][15:8]) && regs_q[0][7:0] == $past(core_wr_data[7:0]))
    else $error("byte op changed upper byte");

  AST_SHADOW_POP: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && shadow_push ##1 ce && shadow_pop && !shadow_push
    |=> regs_q[1] == $past(regs_q[1], 2))
    else $error("shadow pop did not restore");

  AST_LOOP_END: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && loop_end && !loop_start && !core_wr_en && !bus_wr
    |=> regs_q[dscreg_pkg::IDX_LP_END] == $past(shd_lp_q[1]))
    else $error("loop end not restored");

  AST_EXC_WORD: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && exc_entry |=> exc_word_valid_q
    && exc_word_q == {$past(regs_q[dscreg_pkg::IDX_SR][7:0]), 1'b0, $past(pc_q[22:16])})
    else $error("exception word wrong");

  AST_PC_EVEN: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && pc_step && !pc_load |=> pc_q == $past(pc_q) + dscreg_pkg::PC_STEP && !pc_q[0])
    else $error("program counter step wrong");

  AST_PROG_RANGE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && prog_req && !prog_table && prog_addr > dscreg_pkg::PROG_USER_MAX
    |=> !prog_ok_q && !prog_cfg_q)
    else $error("user access beyond program range");

  AST_SAT_POS: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && sat_req && write_saturate_enable && sat_ovf && !sat_acc[39] |=> sat_out_q == dscreg_pkg::SAT_POS)
    else $error("positive saturation missed");

  AST_SAT_NEG: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && sat_req && write_saturate_enable && sat_ovf && sat_acc[39] |=> sat_out_q == dscreg_pkg::SAT_NEG)
    else $error("negative saturation missed");

  AST_SAT_PASS: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && sat_req && !write_saturate_enable && !acc_wr_en
    |=> sat_valid_q && sat_out_q == $past(sat_in) && acc_a == $past(acc_a))
    else $error("saturation off altered data");

  AST_SHF_ZERO: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && shf_req && shf_count == 6'h00 && shf_src == dscreg_pkg::SRC_ACCUMULATOR_B
    |=> shf_valid_q && shf_out_q == $past(acc_b))
    else $error("zero shift changed operand");
endmodule

// >>> tb/dscreg_exec.sv
module dscreg_exec (
  input wire logic aclk,
  output logic call_push,
  output logic exc_entry,
  output logic sat_req,
  output logic shf_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // Issue stage idles with every pulse low
  initial begin
    {call_push, exc_entry, sat_req, shf_req} = 4'h0;
  end
  // One-cycle pulse after a gap; the gap mimics stalls in the issue stage
  task automatic fire(input int k, input int gap);
    repeat (gap + 1) @(posedge aclk);
    case (k)
      0: call_push <= 1'b1;
      1: exc_entry <= 1'b1;
      2: sat_req <= 1'b1;
      default: shf_req <= 1'b1;
    endcase
    @(posedge aclk);
    {call_push, exc_entry, sat_req, shf_req} <= 4'h0;
  endtask
endmodule

// >>> tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic core_wr_en = 0, core_wr_byte = 0, acc_wr_en = 0, acc_wr_sel = 0, call_return = 0;
  logic frame_link = 0, frame_unlink = 0, shadow_push = 0, shadow_pop = 0, loop_start = 0;
  logic loop_end = 0, pc_load = 0, pc_step = 0, prog_req = 0, prog_table = 0, sat_acc_sel = 0;
  logic sat_round_ovf = 0, shf_arith = 0, call_push, exc_entry, sat_req, shf_req;
  logic [4:0] core_wr_idx = 5'h0, core_rd_idx = 5'h0;
  logic [15:0] core_wr_data = 0, frame_size = 0, loop_start_val = 0, loop_end_val = 0;
  logic [15:0] loop_count_val = 0, sat_in = 0, shf_xbus = 0;
  logic [39:0] acc_wr_data = 40'h0;
  logic [22:0] pc_load_val = 23'h0;
  logic [23:0] prog_addr = 24'h0;
  logic [1:0] shf_src = 2'h0;
  logic [5:0] shf_count = 6'h0;
  logic [15:0] core_rd_data_q, exc_word_q, sat_out_q, shf_int_q;
  logic exc_word_valid_q, prog_ok_q, prog_cfg_q, sat_valid_q, shf_valid_q;
  logic [22:0] pc_q;
  logic [39:0] shf_out_q;
  int err_total = 0, tests_run = 0;
  dscreg_core dut_u (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .core_wr_en, .core_wr_idx, .core_wr_byte, .core_wr_data,
    .core_rd_idx, .core_rd_data_q, .acc_wr_en, .acc_wr_sel, .acc_wr_data, .call_push,
    .call_return, .exc_entry, .frame_link, .frame_unlink, .frame_size, .shadow_push,
    .shadow_pop, .loop_start, .loop_end, .loop_start_val, .loop_end_val, .loop_count_val,
    .exc_word_q, .exc_word_valid_q, .pc_load, .pc_load_val, .pc_step, .pc_q, .prog_req,
    .prog_addr, .prog_table, .prog_ok_q, .prog_cfg_q, .sat_req, .sat_acc_sel, .sat_in,
    .sat_round_ovf, .sat_out_q, .sat_valid_q, .shf_req, .shf_src, .shf_xbus, .shf_count,
    .shf_arith, .shf_out_q, .shf_int_q, .shf_valid_q);
  dscreg_exec exec_u (.aclk, .call_push, .exc_entry, .sat_req, .shf_req);
  // 100 MHz core clock
  always #5 aclk = ~aclk;
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [40:0] g, input logic [40:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bounded wait; a stuck handshake ends the run as a failure
  task automatic bound(input int n);
    if (n >= 50) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, dscreg_pkg::RESP_OKAY);
    bound(n);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    bound(n);
  endtask
  function automatic logic [15:0] exp_sat(logic en, logic [39:0] a, logic [15:0] x, logic ro);
    logic ovf;
    ovf = ro | ~(&a[39:31] | ~|a[39:31]);
    if (en & ovf) return a[39] ? dscreg_pkg::SAT_NEG : dscreg_pkg::SAT_POS;
    return x;
  endfunction
  function automatic logic [39:0] exp_shf(logic [39:0] a, logic [15:0] x, logic signed [5:0] c);
    logic signed [39:0] op;
    op = shf_src[1] ? (c >= 0 ? {{8{shf_arith & x[15]}}, x, 16'h0} : {24'h0, x}) : a;
    if (c >= 0) return shf_arith ? op >>> c : op >> c;
    return op << -c;
  endfunction
  initial begin
    logic [31:0] d, u;
    logic [1:0] r;
    logic [39:0] am [2];
    logic [39:0] e;
    am = '{40'h0, 40'h0};
    void'($urandom(57));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h3c, d, r);
    chk(d, dscreg_pkg::SP_RESET);
    wr(8'h3c, 32'h1235);
    rd(8'h3c, d, r);
    chk(d, 32'h1234);
    exec_u.fire(0, 2);
    rd(8'h3c, d, r);
    chk(d, 32'h1238);
    rd(8'h78, d, r);
    chk(r, dscreg_pkg::RESP_SLVERR);
    wr(8'h00, 32'habcd);
    @(posedge aclk);
    {core_wr_en, core_wr_byte, core_wr_idx, core_wr_data} <= {2'h3, 5'h00, 16'h1234};
    @(posedge aclk);
    core_wr_en <= 1'b0;
    rd(8'h00, d, r);
    chk(d, 32'hab34);
    wr(8'h58, 32'h00a5);
    @(posedge aclk);
    {pc_load, pc_load_val} <= {1'b1, 23'h7a1235};
    @(posedge aclk);
    pc_load <= 1'b0;
    #1 chk(pc_q, 23'h7a1234);
    exec_u.fire(1, 0);
    #1 chk({exc_word_valid_q, exc_word_q}, 17'h1a57a);
    @(posedge aclk);
    {prog_req, prog_table, prog_addr} <= {2'h2, 24'h800000};
    @(posedge aclk);
    prog_req <= 1'b0;
    #1 chk(prog_ok_q, 1'b0);
    // Table op with the page bit set reaches configuration space
    wr(8'h5c, 32'h80);
    @(posedge aclk);
    {prog_req, prog_table} <= 2'h3;
    @(posedge aclk);
    prog_req <= 1'b0;
    #1 chk({prog_ok_q, prog_cfg_q}, 2'h3);
    // One step, then an edge frozen by the enable
    @(posedge aclk);
    pc_step <= 1'b1;
    @(posedge aclk);
    ce <= 1'b0;
    @(posedge aclk);
    {ce, pc_step} <= 2'h2;
    #1 chk(pc_q, 23'h7a1236);
    // Shadow round trip; the overwrite between push and pop must vanish
    @(posedge aclk);
    {core_wr_en, core_wr_byte, core_wr_idx, core_wr_data} <= {2'h2, 5'h01, 16'h5a5a};
    @(posedge aclk);
    {shadow_push, core_wr_data} <= {1'b1, 16'h0f0f};
    @(posedge aclk);
    {shadow_push, shadow_pop, core_wr_en, core_rd_idx} <= {3'h2, 5'h01};
    @(posedge aclk);
    shadow_pop <= 1'b0;
    @(posedge aclk);
    #1 chk(core_rd_data_q, 16'h5a5a);
    // Nested loop start, then its end brings back the outer bounds
    @(posedge aclk);
    {loop_start, loop_start_val, loop_end_val, loop_count_val} <= {1'b1, 48'h1111_2222_0003};
    core_rd_idx <= dscreg_pkg::IDX_SR;
    @(posedge aclk);
    {loop_start_val, loop_end_val, loop_count_val} <= 48'h4444_5555_0006;
    @(posedge aclk);
    {loop_start, loop_end} <= 2'h1;
    #1 chk(core_rd_data_q, 16'h02a5);
    @(posedge aclk);
    loop_end <= 1'b0;
    rd(8'h68, d, r);
    chk(d, 32'h2222);
    rd(8'h58, d, r);
    chk(d, 32'h00a5);
    // Frame link and unlink, then a return
    @(posedge aclk);
    {frame_link, frame_size} <= {1'b1, 16'h0010};
    @(posedge aclk);
    {frame_link, frame_unlink} <= 2'h1;
    @(posedge aclk);
    {frame_unlink, call_return} <= 2'h1;
    @(posedge aclk);
    call_return <= 1'b0;
    rd(8'h38, d, r);
    chk(d, 32'h123e);
    rd(8'h3c, d, r);
    chk(d, 32'h1238);
    // Random accumulator loads, saturation and shifts with saturation on, then off
    for (int en = 1; en >= 0; en--) begin
      wr(8'h60, 32'(en));
      repeat (40) begin
        u = $urandom;
        am[u[6]] = u[0] ? {{8{u[31]}}, u} : {u[15:8], $urandom};
        @(posedge aclk);
        {acc_wr_en, acc_wr_sel, acc_wr_data} <= {1'b1, u[6], am[u[6]]};
        {sat_acc_sel, sat_in, sat_round_ovf, shf_arith} <= {u[1], u[31:16], u[2], u[3]};
        {shf_src, shf_xbus} <= {u[5:4], u[15:0]};
        shf_count <= 6'($urandom_range(0, 31) - 16);
        @(posedge aclk);
        acc_wr_en <= 1'b0;
        exec_u.fire(2, u[8]);
        e = {24'h0, exp_sat(en[0], am[sat_acc_sel], sat_in, sat_round_ovf)};
        #1 chk({sat_valid_q, sat_out_q}, {1'b1, e[15:0]});
        exec_u.fire(3, u[9]);
        e = exp_shf(am[shf_src[0]], shf_xbus, shf_count);
        #1 chk({shf_valid_q, shf_out_q}, {1'b1, e});
        chk(shf_int_q, shf_count[5] ? e[15:0] : e[31:16]);
      end
    end
    // Zero count on accumulator B leaves the operand as loaded
    {shf_src, shf_count} <= {2'h1, 6'h00};
    exec_u.fire(3, 0);
    #1 chk(shf_out_q, am[1]);
    rd(8'h40, d, r);
    chk(d, {16'h0, am[0][15:0]});
    wrap_up();
  end
endmodule
